// File: logic/alsu_params.svh
`ifndef ALSU_PARAMS_SVH
`define ALSU_PARAMS_SVH

`define ALSU_NUM_REGS 8
`define ALSU_FLAGS_RST 5'h00
`define ALSU_SMALL_ONE 16'h0001
`define ALSU_SMALL_TWO 16'h0002
`define ALSU_BYTE_ONE 8'h01
`define ALSU_BCD_LO_ADJ 8'h06
`define ALSU_BCD_HI_ADJ 8'h60
`define ALSU_BCD_DIGIT_MAX 4'h9
`define ALSU_BCD_BYTE_MAX 8'h99
`define ALSU_DIV0_QUOT 8'hff

`endif

// File: logic/alsu_pkg.sv
package alsu_pkg;

    typedef enum logic [4:0] {
        op_add, op_sub, op_add_with_carry, op_sub_with_borrow,
        op_plus_one, op_minus_one_op, op_word_add_small, op_word_sub_small,
        op_decimal_adjust_after_add, op_decimal_adjust_after_sub,
        op_unsigned_multiply, op_unsigned_divide, op_compare_op, op_negate,
        op_and, op_or, op_xor, op_invert,
        op_arith_left_shift, op_arith_right_shift, op_logic_left_shift,
        op_logic_right_shift, op_circular_left, op_circular_right,
        op_carry_ring_left, op_carry_ring_right
    } alsu_op_t;

    // byte register index: [2:0] word register, [3] set selects the low byte
    typedef struct packed {
        alsu_op_t op;
        logic word;
        logic imm_src;
        logic [3:0] dst;
        logic [3:0] src_reg;
        logic [15:0] imm;
    } alsu_req_t;

    typedef struct packed {
        logic done;
        logic illegal;
        logic wrote;
        logic [15:0] result;
    } alsu_rsp_t;

    typedef struct packed {
        logic h;
        logic n;
        logic z;
        logic v;
        logic c;
    } alsu_flags_t;

    typedef struct packed {
        logic valid;
        logic [2:0] idx;
        logic [15:0] data;
    } alsu_load_t;

    typedef enum logic {st_idle, st_exec} alsu_state_t;

endpackage

// File: logic/alsu_regfile.sv
`timescale 1ns/100ps
`default_nettype none
`include "alsu_params.svh"

module alsu_regfile (
    // clock
    input wire logic clk_i,
    // read ports, data one cycle after the index
    input wire logic [2:0] rd_a_idx_i,
    input wire logic [2:0] rd_b_idx_i,
    output logic [15:0] rd_a_data_o,
    output logic [15:0] rd_b_data_o,
    // write port
    input wire logic wr_en_i,
    input wire logic [2:0] wr_idx_i,
    input wire logic [15:0] wr_data_i
);

    // no reset: general registers power up undefined
    logic [15:0] mem_q [`ALSU_NUM_REGS];

    always_ff @(posedge clk_i)
    begin
        if (wr_en_i)
        begin
            mem_q[wr_idx_i] <= wr_data_i;
        end
        rd_a_data_o <= mem_q[rd_a_idx_i];
        rd_b_data_o <= mem_q[rd_b_idx_i];
    end

endmodule
`default_nettype wire

// File: logic/alsu_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "alsu_params.svh"

module alsu_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // operation request from the decoder
    input wire logic req_valid_i,
    input wire alsu_pkg::alsu_req_t req_i,
    // register and flag loads from the sequencer
    input wire alsu_pkg::alsu_load_t load_i,
    input wire logic flag_wr_i,
    input wire alsu_pkg::alsu_flags_t flag_data_i,
    // status and results
    output logic busy_o,
    output alsu_pkg::alsu_rsp_t rsp_o,
    output alsu_pkg::alsu_flags_t flags_o
);
    import alsu_pkg::*;

    function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
                                         input logic ci, input logic sub);
        logic [7:0] bb;
        logic ce;
        logic [8:0] s;
        logic [4:0] hs;
        bb = sub ? ~b : b;
        ce = sub ? ~ci : ci;
        s = {1'h0, a} + {1'h0, bb} + {8'h00, ce};
        hs = {1'h0, a[3:0]} + {1'h0, bb[3:0]} + {4'h0, ce};
        // returns h, v, c, result; c is a borrow when subtracting
        return {hs[4] ^ sub, (a[7] == bb[7]) & (s[7] != a[7]), s[8] ^ sub, s[7:0]};
    endfunction

    function automatic logic [18:0] add16(input logic [15:0] a, input logic [15:0] b,
                                          input logic sub);
        logic [15:0] bb;
        logic [16:0] s;
        logic [12:0] hs;
        bb = sub ? ~b : b;
        s = {1'h0, a} + {1'h0, bb} + {16'h0000, sub};
        hs = {1'h0, a[11:0]} + {1'h0, bb[11:0]} + {12'h000, sub};
        return {hs[12] ^ sub, (a[15] == bb[15]) & (s[15] != a[15]), s[16] ^ sub, s[15:0]};
    endfunction

    function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic lo);
        return lo ? w[7:0] : w[15:8];
    endfunction

    alsu_state_t state_q;
    alsu_req_t req_q;
    logic busy_q;
    alsu_rsp_t rsp_q;
    alsu_flags_t flags_q;

    logic [15:0] a_w;
    logic [15:0] b_w;

    // request taken only while idle; a load is refused while busy
    wire take = req_valid_i & ~busy_q;
    wire in_exec = (state_q == st_exec);
    wire load_ok = load_i.valid & ~busy_q;
    wire flag_ok = flag_wr_i & ~busy_q & ~req_valid_i;

    alsu_op_t op;
    assign op = req_q.op;
    wire is_small = (op == op_word_add_small) | (op == op_word_sub_small);
    wire imm_small = (req_q.imm == `ALSU_SMALL_ONE) | (req_q.imm == `ALSU_SMALL_TWO);
    wire addsub = (op == op_add) | (op == op_sub);
    wire word_op = (req_q.word & (addsub | (op == op_compare_op))) | is_small;
    wire bad_sub_imm = (op == op_sub) & req_q.imm_src;
    wire bad_word_imm = req_q.word & req_q.imm_src & (addsub | (op == op_compare_op));
    wire bad_small = is_small & ~(req_q.imm_src & imm_small);
    wire bad_md = req_q.imm_src & ((op == op_unsigned_multiply) | (op == op_unsigned_divide));
    wire illegal_w = bad_sub_imm | bad_word_imm | bad_small | bad_md;

    // operand selection
    wire [7:0] a8 = pick_byte(a_w, req_q.dst[3]);
    wire [7:0] src8 = pick_byte(b_w, req_q.src_reg[3]);
    wire [7:0] b8 = req_q.imm_src ? req_q.imm[7:0] : src8;
    wire [15:0] b16 = req_q.imm_src ? req_q.imm : b_w;
    wire cf = flags_q.c;

    wire is_neg = (op == op_negate);
    wire is_step = (op == op_plus_one) | (op == op_minus_one_op);
    wire ar_sub = (op == op_sub) | (op == op_sub_with_borrow) | (op == op_minus_one_op)
                | (op == op_compare_op) | is_neg;
    wire ar_ci = ((op == op_add_with_carry) | (op == op_sub_with_borrow)) & cf;
    wire [7:0] ar_a = is_neg ? 8'h00 : a8;
    wire [7:0] ar_b = is_neg ? a8 : (is_step ? `ALSU_BYTE_ONE : b8);
    wire [10:0] sum8 = add8(ar_a, ar_b, ar_ci, ar_sub);
    wire w_sub = (op == op_sub) | (op == op_compare_op) | (op == op_word_sub_small);
    wire [18:0] sum16 = add16(a_w, b16, w_sub);

    // decimal adjust looks at h and c left by the previous add or subtract
    wire daa_lo = flags_q.h | (a8[3:0] > `ALSU_BCD_DIGIT_MAX);
    wire daa_hi = cf | (a8 > `ALSU_BCD_BYTE_MAX);
    wire [7:0] daa_r = a8 + (daa_lo ? `ALSU_BCD_LO_ADJ : 8'h00)
                     + (daa_hi ? `ALSU_BCD_HI_ADJ : 8'h00);
    wire [7:0] das_r = a8 - (flags_q.h ? `ALSU_BCD_LO_ADJ : 8'h00)
                     - (cf ? `ALSU_BCD_HI_ADJ : 8'h00);

    wire [15:0] prod = a8 * src8;
    wire div0 = (src8 == 8'h00);
    wire [15:0] quot16 = div0 ? 16'h0000 : a_w / {8'h00, src8};
    wire [15:0] rem16 = div0 ? a_w : a_w % {8'h00, src8};
    wire [7:0] quot = div0 ? `ALSU_DIV0_QUOT : quot16[7:0];

    logic [7:0] r8;
    logic [15:0] r16;
    logic wr_d;
    alsu_flags_t fl_d;

    always_comb
    begin
        r8 = sum8[7:0];
        r16 = sum16[15:0];
        wr_d = 1'h1;
        fl_d = flags_q;
        case (op)
            op_add, op_sub, op_compare_op, op_add_with_carry, op_sub_with_borrow, op_negate:
            begin
                wr_d = (op != op_compare_op);
                if (word_op)
                begin
                    fl_d.h = sum16[18];
                    fl_d.v = sum16[17];
                    fl_d.c = sum16[16];
                end
                else
                begin
                    fl_d.h = sum8[10];
                    fl_d.v = sum8[9];
                    fl_d.c = sum8[8];
                end
            end
            op_plus_one, op_minus_one_op:
                fl_d.v = sum8[9];
            op_word_add_small, op_word_sub_small:
                fl_d = flags_q;
            op_decimal_adjust_after_add:
            begin
                r8 = daa_r;
                fl_d.c = daa_hi;
            end
            op_decimal_adjust_after_sub:
                r8 = das_r;
            op_unsigned_multiply:
            begin
                r16 = prod;
                fl_d.v = 1'h0;
            end
            op_unsigned_divide:
            begin
                r16 = {rem16[7:0], quot};
                fl_d.v = div0;
            end
            op_and, op_or, op_xor, op_invert:
            begin
                r8 = (op == op_and) ? (a8 & b8) :
                     (op == op_or) ? (a8 | b8) :
                     (op == op_xor) ? (a8 ^ b8) : ~a8;
                fl_d.v = 1'h0;
            end
            op_arith_left_shift, op_logic_left_shift:
            begin
                r8 = {a8[6:0], 1'h0};
                fl_d.c = a8[7];
                fl_d.v = (op == op_arith_left_shift) & (a8[7] ^ a8[6]);
            end
            op_arith_right_shift, op_logic_right_shift:
            begin
                r8 = {(op == op_arith_right_shift) & a8[7], a8[7:1]};
                fl_d.c = a8[0];
                fl_d.v = 1'h0;
            end
            op_circular_left, op_carry_ring_left:
            begin
                r8 = {a8[6:0], (op == op_circular_left) ? a8[7] : cf};
                fl_d.c = a8[7];
                fl_d.v = 1'h0;
            end
            op_circular_right, op_carry_ring_right:
            begin
                r8 = {(op == op_circular_right) ? a8[0] : cf, a8[7:1]};
                fl_d.c = a8[0];
                fl_d.v = 1'h0;
            end
            default:
                wr_d = 1'h0;
        endcase
        // negative and zero follow the stored width of the result, except divide: n from the divisor sign, z set on divide by zero
        if (word_op | (op == op_unsigned_multiply))
        begin
            fl_d.n = r16[15];
            fl_d.z = (r16 == 16'h0000);
        end
        else if (op == op_unsigned_divide)
        begin
            fl_d.n = src8[7];
            fl_d.z = div0;
        end
        else
        begin
            fl_d.n = r8[7];
            // carry chains keep a zero flag cleared earlier, so multi-byte tests work
            fl_d.z = (r8 == 8'h00) & (((op != op_add_with_carry) & (op != op_sub_with_borrow))
                     | flags_q.z);
        end
    end

    wire wide_res = word_op | (op == op_unsigned_multiply) | (op == op_unsigned_divide);
    wire [15:0] wdata = wide_res ? r16
                      : (req_q.dst[3] ? {a_w[15:8], r8} : {r8, a_w[7:0]});
    wire do_wr = in_exec & wr_d & ~illegal_w;
    wire rf_wr = do_wr | (~in_exec & load_ok);
    wire [2:0] rf_idx = in_exec ? req_q.dst[2:0] : load_i.idx;
    wire [15:0] rf_data = in_exec ? wdata : load_i.data;

    alsu_regfile u_regs (
        .clk_i(clk_i),
        .rd_a_idx_i(req_i.dst[2:0]),
        .rd_b_idx_i(req_i.src_reg[2:0]),
        .rd_a_data_o(a_w),
        .rd_b_data_o(b_w),
        .wr_en_i(rf_wr),
        .wr_idx_i(rf_idx),
        .wr_data_i(rf_data)
    );

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            state_q <= st_idle;
            busy_q <= 1'h0;
            req_q <= '0;
            rsp_q <= '0;
            flags_q <= `ALSU_FLAGS_RST;
        end
        else
        begin
            state_q <= take ? st_exec : st_idle;
            busy_q <= take;
            if (take)
                req_q <= req_i;
            rsp_q.done <= in_exec;
            if (in_exec)
            begin
                rsp_q.illegal <= illegal_w;
                rsp_q.wrote <= do_wr;
                rsp_q.result <= wr_d ? wdata : r16;
            end
            if (in_exec & ~illegal_w)
                flags_q <= fl_d;
            else if (flag_ok)
                flags_q <= flag_data_i;
        end
    end

    assign busy_o = busy_q;
    assign rsp_o = rsp_q;
    assign flags_o = flags_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_take;
        req_valid_i && !busy_q;
    endsequence
    sequence s_refused;
        ##2 (rsp_o.done && rsp_o.illegal && !rsp_o.wrote);
    endsequence
    sequence s_exec(alsu_op_t o);
        in_exec && !illegal_w && op == o;
    endsequence

    property p_sub_imm_refused;
        s_take ##0 (req_i.op == op_sub && req_i.imm_src) |-> s_refused;
    endproperty
    a_sub_imm_refused: assert property (p_sub_imm_refused) else $error("sub with immediate taken");

    property p_word_imm_refused;
        s_take ##0 (req_i.word && req_i.imm_src && req_i.op == op_add) |-> s_refused;
    endproperty
    a_word_imm_refused: assert property (p_word_imm_refused) else $error("word add imm taken");

    property p_small_imm;
        s_take ##0 (req_i.op == op_word_add_small && req_i.imm > `ALSU_SMALL_TWO) |-> s_refused;
    endproperty
    a_small_imm: assert property (p_small_imm) else $error("small add out of range taken");

    property p_compare_no_write;
        s_take ##0 (req_i.op == op_compare_op) |-> ##2 (rsp_o.done && !rsp_o.wrote);
    endproperty
    a_compare_no_write: assert property (p_compare_no_write) else $error("compare wrote");

    property p_negate;
        s_exec(op_negate) |=>
            pick_byte(rsp_o.result, $past(req_q.dst[3])) == 8'(8'h00 - $past(a8));
    endproperty
    a_negate: assert property (p_negate) else $error("negate result wrong");

    property p_invert;
        s_exec(op_invert) |=> pick_byte(rsp_o.result, $past(req_q.dst[3])) == ~$past(a8);
    endproperty
    a_invert: assert property (p_invert) else $error("invert result wrong");

    property p_ring_left;
        s_exec(op_carry_ring_left) |=>
            {flags_o.c, pick_byte(rsp_o.result, $past(req_q.dst[3]))} == {$past(a8), $past(cf)};
    endproperty
    a_ring_left: assert property (p_ring_left) else $error("carry ring left wrong");

    property p_plus_one_keeps_c;
        s_take ##0 (req_i.op == op_plus_one) |-> ##2 (flags_o.c == $past(flags_o.c, 2));
    endproperty
    a_plus_one_keeps_c: assert property (p_plus_one_keeps_c) else $error("plus one moved carry");

    property p_multiply;
        s_exec(op_unsigned_multiply) |=>
            rsp_o.result == {8'h00, $past(a8)} * {8'h00, $past(src8)};
    endproperty
    a_multiply: assert property (p_multiply) else $error("product wrong");

    property p_divide;
        s_exec(op_unsigned_divide) ##0 !div0 |=>
            rsp_o.result[7:0] == 8'($past(a_w) / $past(src8))
            && rsp_o.result[15:8] == 8'($past(a_w) % $past(src8));
    endproperty
    a_divide: assert property (p_divide) else $error("divide wrong");

endmodule
`default_nettype wire

// File: sim/alsu_seq_model.sv
`timescale 1ns/100ps
`default_nettype none

module alsu_seq_model (
    // clock
    input wire logic clk_i,
    // answers from the unit
    input wire logic busy_i,
    input wire alsu_pkg::alsu_rsp_t rsp_i,
    // requests and loads toward the unit
    output logic req_valid_o,
    output alsu_pkg::alsu_req_t req_o,
    output alsu_pkg::alsu_load_t load_o,
    output logic flag_wr_o,
    output alsu_pkg::alsu_flags_t flag_data_o
);
    import alsu_pkg::*;

    initial
    begin
        req_valid_o = 1'b0;
        req_o = '0;
        load_o = '0;
        flag_wr_o = 1'b0;
        flag_data_o = '0;
    end

    // released fields show the inverse so a late sample never sees the old value
    task automatic load_reg(input logic [2:0] idx, input logic [15:0] d);
        @(posedge clk_i);
        load_o <= '{1'b1, idx, d};
        @(posedge clk_i);
        load_o <= '{1'b0, ~idx, ~d};
    endtask

    task automatic load_flags(input alsu_flags_t f);
        @(posedge clk_i);
        flag_wr_o <= 1'b1;
        flag_data_o <= f;
        @(posedge clk_i);
        flag_wr_o <= 1'b0;
        flag_data_o <= ~f;
    endtask

    // only called while idle, so the request is taken on the edge after it rises
    task automatic issue(input alsu_req_t r, output alsu_rsp_t s, output logic ok);
        int n;
        ok = 1'b0;
        s = '0;
        @(posedge clk_i);
        req_valid_o <= 1'b1;
        req_o <= r;
        @(posedge clk_i);
        req_valid_o <= 1'b0;
        req_o <= alsu_req_t'(~r);
        for (n = 0; n < 8 && !ok; n++)
        begin
            @(posedge clk_i);
            #1;
            if (rsp_i.done === 1'b1 && busy_i === 1'b0)
            begin
                ok = 1'b1;
                s = rsp_i;
            end
        end
    endtask
endmodule

`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "alsu_params.svh"

module testbench;
    import alsu_pkg::*;

    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    wire logic req_valid;
    wire alsu_req_t req;
    wire alsu_load_t load;
    wire logic flag_wr;
    wire alsu_flags_t flag_data;
    logic busy_o;
    alsu_rsp_t rsp_o;
    alsu_flags_t flags_o;
    int errors = 0;
    int checks = 0;
    logic [15:0] rf [8];
    alsu_req_t r;
    int i;
    int seed;

    always #25 clk_i = ~clk_i;

    alsu_top alsu_top_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid),
        .req_i(req), .load_i(load), .flag_wr_i(flag_wr), .flag_data_i(flag_data),
        .busy_o(busy_o), .rsp_o(rsp_o), .flags_o(flags_o));
    alsu_seq_model alsu_seq_model_inst (.clk_i(clk_i), .busy_i(busy_o), .rsp_i(rsp_o),
        .req_valid_o(req_valid), .req_o(req), .load_o(load), .flag_wr_o(flag_wr),
        .flag_data_o(flag_data));

    task automatic results;
        if (errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk_word(input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic chk_bit(input logic e, input logic g);
        chk_word({15'h0000, e}, {15'h0000, g});
    endtask

    // returns {carry, result}; byte results sit in the low byte
    function automatic logic [16:0] calc(alsu_op_t o, logic [15:0] a, logic [15:0] b,
                                         logic w, logic ci, logic h);
        logic [8:0] x;
        x = {ci, a[7:0]};
        case (o)
            op_add: if (w) return {1'b0, a} + {1'b0, b}; else x = {1'b0, a[7:0]} + b[7:0];
            op_sub, op_compare_op:
                if (w) return {1'b0, a} - {1'b0, b}; else x = {1'b0, a[7:0]} - b[7:0];
            op_add_with_carry: x = {1'b0, a[7:0]} + b[7:0] + ci;
            op_sub_with_borrow: x = {1'b0, a[7:0]} - b[7:0] - ci;
            op_plus_one: x = {ci, a[7:0] + 8'h01};
            op_minus_one_op: x = {ci, a[7:0] - 8'h01};
            op_word_add_small: return {ci, a + b};
            op_word_sub_small: return {ci, a - b};
            op_unsigned_multiply: return {ci, 16'(a[7:0]) * 16'(b[7:0])};
            op_negate: x = 9'h000 - {1'b0, a[7:0]};
            op_decimal_adjust_after_add:
            begin
                x[8] = ci || (a[7:0] > `ALSU_BCD_BYTE_MAX);
                x[7:0] = a[7:0] + (x[8] ? `ALSU_BCD_HI_ADJ : 8'h00);
                if (h || (a[3:0] > `ALSU_BCD_DIGIT_MAX))
                    x[7:0] = x[7:0] + `ALSU_BCD_LO_ADJ;
            end
            op_decimal_adjust_after_sub:
                x[7:0] = a[7:0] - (h ? `ALSU_BCD_LO_ADJ : 8'h00)
                         - (ci ? `ALSU_BCD_HI_ADJ : 8'h00);
            op_and: x = {ci, a[7:0] & b[7:0]};
            op_or: x = {ci, a[7:0] | b[7:0]};
            op_xor: x = {ci, a[7:0] ^ b[7:0]};
            op_invert: x = {ci, ~a[7:0]};
            op_arith_left_shift, op_logic_left_shift: x = {a[7], a[6:0], 1'b0};
            op_arith_right_shift: x = {a[0], a[7], a[7:1]};
            op_logic_right_shift: x = {a[0], 1'b0, a[7:1]};
            op_circular_left: x = {a[7], a[6:0], a[7]};
            op_circular_right: x = {a[0], a[0], a[7:1]};
            op_carry_ring_left: x = {a[7], a[6:0], ci};
            op_carry_ring_right: x = {a[0], ci, a[7:1]};
            default: x = {ci, a[7:0]};
        endcase
        return {x[8], 8'h00, x[7:0]};
    endfunction

    // two's-complement overflow from operand and result signs
    function automatic logic vcalc(alsu_op_t o, logic [15:0] a, logic [15:0] b,
                                   logic [15:0] r, logic w);
        logic sa;
        logic sb;
        logic sr;
        sa = w ? a[15] : a[7];
        sb = w ? b[15] : b[7];
        sr = w ? r[15] : r[7];
        case (o)
            op_add, op_add_with_carry: return (sa == sb) && (sr != sa);
            op_sub, op_compare_op, op_sub_with_borrow: return (sa != sb) && (sr != sa);
            op_negate: return a[7] && r[7];
            op_plus_one: return !a[7] && r[7];
            op_minus_one_op: return a[7] && !r[7];
            op_arith_left_shift: return a[7] ^ a[6];
            default: return 1'b0;
        endcase
    endfunction

    task automatic run(input alsu_req_t q, input logic bad);
        alsu_flags_t f;
        alsu_rsp_t s;
        logic ok;
        logic wop;
        logic rw;
        logic [15:0] a;
        logic [15:0] rb;
        logic [7:0] bb;
        logic [15:0] oa;
        logic [15:0] ob;
        logic [16:0] x;
        logic [15:0] e;
        f = alsu_flags_t'(5'($urandom));
        alsu_seq_model_inst.load_flags(f);
        a = rf[q.dst[2:0]];
        rb = q.imm_src ? q.imm : rf[q.src_reg[2:0]];
        bb = (q.imm_src || q.src_reg[3]) ? rb[7:0] : rb[15:8];
        wop = (q.word && q.op inside {op_add, op_sub, op_compare_op})
            || q.op inside {op_word_add_small, op_word_sub_small};
        rw = wop || q.op == op_unsigned_multiply;
        oa = wop ? a : {8'h00, q.dst[3] ? a[7:0] : a[15:8]};
        ob = wop ? rb : {8'h00, bb};
        x = calc(q.op, oa, ob, wop, f.c, f.h);
        e = rw ? x[15:0] : (q.dst[3] ? {a[15:8], x[7:0]} : {x[7:0], a[7:0]});
        alsu_seq_model_inst.issue(q, s, ok);
        chk_bit(1'b1, ok);
        if (bad)
        begin
            chk_bit(1'b1, s.illegal);
            chk_bit(1'b0, s.wrote);
            chk_word({11'h000, f}, {11'h000, flags_o});
        end
        else if (q.op == op_unsigned_divide)
        begin
            chk_bit(1'b1, s.wrote);
            e = (bb == 8'h00) ? {a[7:0], `ALSU_DIV0_QUOT} : {8'(a % bb), 8'(a / bb)};
            chk_word(e, s.result);
            rf[q.dst[2:0]] = s.result;
        end
        else if (q.op == op_compare_op)
        begin
            chk_bit(1'b0, s.wrote);
            chk_bit(rw ? x[15:0] == 16'h0000 : x[7:0] == 8'h00, flags_o.z);
            chk_bit(x[16], flags_o.c);
            chk_bit(vcalc(q.op, oa, ob, x[15:0], wop), flags_o.v);
        end
        else
        begin
            chk_bit(1'b0, s.illegal);
            chk_bit(1'b1, s.wrote);
            chk_word(e, s.result);
            chk_bit(x[16], flags_o.c);
            if (q.op inside {op_word_add_small, op_word_sub_small, op_decimal_adjust_after_add,
                             op_decimal_adjust_after_sub})
                chk_bit(f.v, flags_o.v);
            else
                chk_bit(vcalc(q.op, oa, ob, x[15:0], wop), flags_o.v);
            rf[q.dst[2:0]] = e;
            if (!(q.op inside {op_word_add_small, op_word_sub_small}))
            begin
                chk_bit(rw ? x[15] : x[7], flags_o.n);
                chk_bit((rw ? x[15:0] == 16'h0000 : x[7:0] == 8'h00)
                        && (f.z || !(q.op inside {op_add_with_carry, op_sub_with_borrow})),
                        flags_o.z);
            end
        end
    endtask

    function automatic alsu_req_t mk(alsu_op_t o, logic w, logic im, logic [15:0] m);
        return '{o, w, im, 4'h8, 4'h1, m};
    endfunction

    initial
    begin
        repeat (30000) @(posedge clk_i);
        errors++;
        results;
    end

    initial
    begin
        seed = $urandom(87);
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk_bit(1'b0, busy_o);
        chk_word(16'h0000, {11'h000, flags_o});
        for (i = 0; i < 8; i++)
        begin
            rf[i] = 16'($urandom);
            alsu_seq_model_inst.load_reg(3'(i), rf[i]);
        end
        run(mk(op_sub, 1'b0, 1'b1, 16'h0005), 1'b1);
        run(mk(op_add, 1'b1, 1'b1, 16'h0005), 1'b1);
        run(mk(op_compare_op, 1'b1, 1'b1, 16'h0005), 1'b1);
        run(mk(op_word_add_small, 1'b1, 1'b1, 16'h0003), 1'b1);
        run(mk(op_word_sub_small, 1'b1, 1'b1, 16'h0000), 1'b1);
        run(mk(op_word_add_small, 1'b1, 1'b1, 16'h0002), 1'b0);
        run(mk(op_word_sub_small, 1'b1, 1'b1, 16'h0001), 1'b0);
        for (i = 0; i < 400; i++)
        begin
            r.op = alsu_op_t'($urandom_range(0, 25));
            r.dst = 4'($urandom);
            r.src_reg = 4'($urandom);
            r.imm = 16'($urandom);
            r.word = 1'b0;
            r.imm_src = 1'b0;
            case (r.op)
                op_add, op_sub, op_compare_op:
                begin
                    r.word = 1'($urandom);
                    r.imm_src = !r.word && r.op != op_sub && 1'($urandom);
                end
                op_add_with_carry, op_sub_with_borrow, op_and, op_or, op_xor:
                    r.imm_src = 1'($urandom);
                op_word_add_small, op_word_sub_small:
                begin
                    r.word = 1'b1;
                    r.imm_src = 1'b1;
                    r.imm = 16'($urandom_range(1, 2));
                end
                default: r.imm_src = 1'b0;
            endcase
            run(r, 1'b0);
        end
        results;
    end
endmodule

`default_nettype wire
